// [hw/sbpsc_pkg.sv]
// package: constants and types for the standby pin state control block
package sbpsc_pkg;
  // ==========================================================
  // power / cpu states
  typedef enum logic [2:0] {
    SBPSC_ST_POR = 3'h0,
    SBPSC_ST_RSTIN = 3'h1,
    SBPSC_ST_INTRST = 3'h3,
    SBPSC_ST_RUN = 3'h2,
    SBPSC_ST_STBY = 3'h6
  } sbpsc_state_type;

  // ==========================================================
  // per-pin function select encoding
  localparam logic [2:0] SBPSC_FN_GPIO = 3'h0;
  localparam logic [2:0] SBPSC_FN_TRACE = 3'h1;
  localparam logic [2:0] SBPSC_FN_EXTINT = 3'h2;
  localparam logic [2:0] SBPSC_FN_NMI = 3'h3;
  localparam logic [2:0] SBPSC_FN_JTAG = 3'h4;
  localparam logic [2:0] SBPSC_FN_PERIPH = 3'h5;
  localparam int SBPSC_FN_W = 3;

  // ==========================================================
  // standby pin level values and reset values
  localparam logic SBPSC_SPL_HOLD = 1'h0;
  localparam logic SBPSC_SPL_FLOAT = 1'h1;
  localparam logic SBPSC_HOLD_RST = 1'h0;
  localparam int SBPSC_NUM_PINS = 8;

  // internal reset length after the reset pin goes high
  localparam int SBPSC_INTRST_NS = 100;
  localparam int SBPSC_CLK_NS = 10;
  localparam int SBPSC_INTRST_CYC =
    (SBPSC_INTRST_NS + SBPSC_CLK_NS - 1) / SBPSC_CLK_NS;
  localparam int SBPSC_CNT_W = 8;
endpackage

// [hw/sbpsc_pin_cell.sv]
// module: one general pin cell with drive/input gating and hold latch
`timescale 1ns/1ps
`default_nettype none
module sbpsc_pin_cell
  import sbpsc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // state
  input wire logic i_por,
  input wire logic i_reset_like,
  input wire logic i_run,
  input wire logic i_stby,
  input wire logic i_spl,
  input wire logic [sbpsc_pkg::SBPSC_FN_W-1:0] i_fn,
  // core side
  input wire logic i_core_out,
  input wire logic i_core_oe,
  input wire logic i_trace_out,
  output logic o_core_in,
  // pad side
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe
);
  logic held_out;
  logic held_oe;
  wire is_keep_fn = (i_fn == SBPSC_FN_EXTINT) || (i_fn == SBPSC_FN_NMI)
    || (i_fn == SBPSC_FN_JTAG);
  wire is_trace = (i_fn == SBPSC_FN_TRACE);
  wire is_port = (i_fn == SBPSC_FN_GPIO);
  wire float_now = i_stby && (i_spl == SBPSC_SPL_FLOAT)
    && !is_keep_fn && !is_trace;
  // a trace pin with the level bit at 0 holds like a running peripheral
  wire hold_now = i_stby && !float_now && !trace_now;
  wire trace_now = i_stby && is_trace && (i_spl == SBPSC_SPL_FLOAT);
  wire next_in_en = !i_por && !float_now;
  // ==========================================================
  // hold latch: capture last run-mode drive of a port
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      held_out <= SBPSC_HOLD_RST;
      held_oe <= SBPSC_HOLD_RST;
    end else if (i_ce && i_run) begin
      held_out <= i_core_out;
      held_oe <= i_core_oe;
    end
  end
  // a port keeps its captured value; a running peripheral keeps driving
  wire hold_out = is_port ? held_out : i_core_out;
  wire hold_oe = is_port ? held_oe : i_core_oe;
  // ==========================================================
  // output drive
  always_comb begin
    o_pad_out = 1'b0;
    o_pad_oe = 1'b0;
    if (trace_now) begin
      o_pad_out = i_trace_out;
      o_pad_oe = 1'b1;
    end else if (hold_now) begin
      o_pad_out = hold_out;
      o_pad_oe = hold_oe;
    end else if (i_run) begin
      o_pad_out = i_core_out;
      o_pad_oe = i_core_oe;
    end else if (i_reset_like && is_keep_fn && (i_fn == SBPSC_FN_JTAG)) begin
      o_pad_oe = 1'b0;
    end
  end
  assign o_core_in = next_in_en ? i_pad_in : 1'b0;
endmodule // sbpsc_pin_cell
`default_nettype wire

// [hw/sbpsc_top.sv]
// module: pin state control across power, reset, run and standby
// ==========================================================
// What this block does
// - the level bit keeps pin states at 0 and floats port pins at 1.
// - a pin whose input is disabled gives a constant low to the core.
// - a high-impedance pin has its output driver turned off.
// - a held pin keeps its prior state, following a running peripheral.
// - a port pin keeps driving its last output value while held.
// - the reset pin is active low and holds reset; high leads on to run.
// - interrupt pins keep their state in run and standby.
// - trace pins keep driving trace data in standby with the level bit 1.
// - oscillator output is high in power-on, reset and stop; input low.
// - the reset pin keeps its pull-up and input active in every state.
`timescale 1ns/1ps
`default_nettype none
module sbpsc_top
  import sbpsc_pkg::*;
#(
  parameter int NUM_PINS = sbpsc_pkg::SBPSC_NUM_PINS,
  parameter int INTRST_CYC = sbpsc_pkg::SBPSC_INTRST_CYC
) (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // power and mode requests
  input wire logic i_power_stable,
  input wire logic i_stby_req,
  input wire logic i_wake,
  input wire logic i_osc_stop,
  input wire logic i_standby_pin_level_select,
  // reset pin
  input wire logic i_external_reset_low_input_n,
  output logic o_rst_pullup_en,
  output logic o_rst_in,
  // main oscillator output pin
  input wire logic i_osc_core_out,
  output logic o_osc_pad_out,
  output logic o_osc_pad_oe,
  output logic o_osc_core_in,
  // general pins
  input wire logic [NUM_PINS*sbpsc_pkg::SBPSC_FN_W-1:0] i_fn_sel,
  input wire logic [NUM_PINS-1:0] i_core_out,
  input wire logic [NUM_PINS-1:0] i_core_oe,
  input wire logic [NUM_PINS-1:0] i_trace_out,
  input wire logic [NUM_PINS-1:0] i_pad_in,
  output logic [NUM_PINS-1:0] o_core_in,
  output logic [NUM_PINS-1:0] o_pad_out,
  output logic [NUM_PINS-1:0] o_pad_oe,
  // status
  output logic [2:0] o_state,
  output logic o_int_reset
);
  import sbpsc_pkg::*;
  // ==========================================================
  // state decoding
  // the pin cells and the status outputs both need these, so they
  // live in one place and cannot drift apart
  function automatic logic sbpsc_in_reset(input sbpsc_state_type s);
    return (s == SBPSC_ST_RSTIN) || (s == SBPSC_ST_INTRST);
  endfunction
  function automatic logic sbpsc_in_live(input sbpsc_state_type s);
    return (s == SBPSC_ST_RUN) || (s == SBPSC_ST_STBY);
  endfunction
  // ==========================================================
  // state and internal reset counter
  sbpsc_state_type state;
  sbpsc_state_type next_seq_state;
  sbpsc_state_type next_state;
  logic [SBPSC_CNT_W-1:0] rst_cnt;
  logic [SBPSC_CNT_W-1:0] next_rst_cnt;
  logic rst_done;
  // the counter width is fixed; a longer internal reset needs a wider
  // counter, otherwise the last count is truncated and the internal reset ends early
  localparam logic [SBPSC_CNT_W-1:0] RST_LAST =
    SBPSC_CNT_W'(INTRST_CYC - 1);
  assign rst_done = (rst_cnt == RST_LAST);
  // ==========================================================
  // normal sequence, before the overriding conditions
  always_comb begin
    next_seq_state = state;
    case (state)
      SBPSC_ST_POR: begin
        // wait for the supply before looking at the reset pin
        if (i_power_stable) begin
          next_seq_state = SBPSC_ST_RSTIN;
        end
      end
      SBPSC_ST_RSTIN: begin
        // a high reset pin starts the internal reset
        if (i_external_reset_low_input_n) begin
          next_seq_state = SBPSC_ST_INTRST;
        end
      end
      SBPSC_ST_INTRST: begin
        // internal reset lasts INTRST_CYC enabled edges
        if (rst_done) begin
          next_seq_state = SBPSC_ST_RUN;
        end
      end
      SBPSC_ST_RUN: begin
        // standby requests are only honoured from run
        if (i_stby_req) begin
          next_seq_state = SBPSC_ST_STBY;
        end
      end
      SBPSC_ST_STBY: begin
        // wake is only looked at in standby
        if (i_wake) begin
          next_seq_state = SBPSC_ST_RUN;
        end
      end
      default: begin
        // an illegal code restarts from power-on
        next_seq_state = SBPSC_ST_POR;
      end
    endcase
  end
  // ==========================================================
  // overrides: power loss first, then a low reset pin, from any state
  // the pin wins over standby so a board can always recover the device
  always_comb begin
    if (!i_power_stable) begin
      next_state = SBPSC_ST_POR;
    end else if (!i_external_reset_low_input_n) begin
      next_state = SBPSC_ST_RSTIN;
    end else begin
      next_state = next_seq_state;
    end
  end
  // ==========================================================
  // internal reset counter: cleared in the reset-input state, counting
  // only in the internal reset state
  always_comb begin
    next_rst_cnt = rst_cnt;
    if (state == SBPSC_ST_RSTIN) begin
      next_rst_cnt = '0;
    end else if (state == SBPSC_ST_INTRST) begin
      next_rst_cnt = rst_cnt + SBPSC_CNT_W'(1);
    end
  end
  // ==========================================================
  // registers; a low clock enable freezes both, so a frozen
  // internal reset simply lasts longer
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= SBPSC_ST_POR;
    end else if (i_ce) begin
      state <= next_state;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rst_cnt <= '0;
    end else if (i_ce) begin
      rst_cnt <= next_rst_cnt;
    end
  end
  // ==========================================================
  // decoded state for the pin cells
  logic st_por;
  logic st_run;
  logic st_stby;
  logic st_reset_like;
  assign st_por = (state == SBPSC_ST_POR);
  assign st_run = (state == SBPSC_ST_RUN);
  assign st_stby = (state == SBPSC_ST_STBY);
  assign st_reset_like = sbpsc_in_reset(state);
  // ==========================================================
  // status
  // internal reset is reported in every state where the core is held
  assign o_state = state;
  assign o_int_reset = !sbpsc_in_live(state);
  // ==========================================================
  // reset pin: always pulled up and readable, so the device can be
  // pulled out of any state, standby included
  assign o_rst_pullup_en = 1'b1;
  assign o_rst_in = i_external_reset_low_input_n;
  // ==========================================================
  // oscillator output pin
  // forced high whenever the crystal is not running, so the load
  // sees a defined level; its input path is never used
  logic osc_force_high;
  assign osc_force_high = st_por || st_reset_like || i_osc_stop;
  assign o_osc_pad_out = osc_force_high ? 1'b1 : i_osc_core_out;
  assign o_osc_pad_oe = 1'b1;
  assign o_osc_core_in = 1'b0;
  // ==========================================================
  // general pins: one cell per pin, each with its own function field
  // the level bit is shared; per-pin standby levels are not offered
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      logic [SBPSC_FN_W-1:0] pin_fn;
      assign pin_fn = i_fn_sel[g*SBPSC_FN_W +: SBPSC_FN_W];
      sbpsc_pin_cell u_cell (
        // clock and enable
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        // decoded state
        .i_por(st_por),
        .i_reset_like(st_reset_like),
        .i_run(st_run),
        .i_stby(st_stby),
        // level bit and function
        .i_spl(i_standby_pin_level_select),
        .i_fn(pin_fn),
        // core and pad side
        .i_core_out(i_core_out[g]),
        .i_core_oe(i_core_oe[g]),
        .i_trace_out(i_trace_out[g]),
        .o_core_in(o_core_in[g]),
        .i_pad_in(i_pad_in[g]),
        .o_pad_out(o_pad_out[g]),
        .o_pad_oe(o_pad_oe[g])
      );
    end
  endgenerate
endmodule // sbpsc_top
`default_nettype wire

// [test/sbpsc_chk_sva.sv]
// checker: port-level assertions for the pin state control block
`timescale 1ns/1ps
`default_nettype none
module sbpsc_chk
  import sbpsc_pkg::*;
#(
  parameter int NUM_PINS = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // watched inputs
  input wire logic i_power_stable,
  input wire logic i_external_reset_low_input_n,
  input wire logic i_osc_stop,
  input wire logic i_standby_pin_level_select,
  input wire logic [NUM_PINS*SBPSC_FN_W-1:0] i_fn_sel,
  // watched outputs
  input wire logic o_rst_pullup_en,
  input wire logic o_rst_in,
  input wire logic o_osc_pad_out,
  input wire logic o_osc_core_in,
  input wire logic [NUM_PINS-1:0] o_core_in,
  input wire logic [NUM_PINS-1:0] o_pad_oe,
  input wire logic [2:0] o_state,
  input wire logic o_int_reset
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // ==========================================================
  // state sequences
  // state only moves on enabled edges, so the pin-up step is qualified by it
  sequence s_pin_up;
    o_state == SBPSC_ST_RSTIN && i_external_reset_low_input_n &&
      i_power_stable && i_ce;
  endsequence
  sequence s_int_rst;
    o_state == SBPSC_ST_INTRST;
  endsequence
  wire logic live = o_state == SBPSC_ST_RUN || o_state == SBPSC_ST_STBY;
  wire logic fl0 = o_state == SBPSC_ST_STBY && i_standby_pin_level_select &&
    i_fn_sel[2:0] == SBPSC_FN_GPIO;
  wire logic st_run = o_state == SBPSC_ST_RUN;
  wire logic st_por = o_state == SBPSC_ST_POR;
  wire logic st_rstin = o_state == SBPSC_ST_RSTIN;
  wire logic pin_ok = o_rst_pullup_en &&
    (o_rst_in == i_external_reset_low_input_n);
  wire logic osc_hi_due = !live || i_osc_stop;
  wire logic pwr_lost = i_ce && !i_power_stable;
  wire logic pin_low = i_ce && i_power_stable &&
    !i_external_reset_low_input_n;
  // ==========================================================
  AST_PULLUP: assert property (pin_ok)
    else $error("reset pin pull-up or input lost");
  AST_OSC_IN: assert property (!o_osc_core_in)
    else $error("oscillator input path not low");
  AST_OSC_HI: assert property (osc_hi_due |-> o_osc_pad_out)
    else $error("oscillator output not high");
  AST_PWR_LOSS: assert property (pwr_lost |=> st_por)
    else $error("power loss did not force power-on state");
  AST_PIN_LOW: assert property (pin_low |=> st_rstin)
    else $error("low reset pin did not hold reset");
  AST_PIN_HIGH: assert property (s_pin_up |=> s_int_rst)
    else $error("high reset pin did not start internal reset");
  AST_TO_RUN: assert property (s_int_rst |-> ##[1:20] st_run)
    else $error("internal reset did not end in run");
  AST_INT_RST: assert property (o_int_reset == !live)
    else $error("internal reset status wrong");
  AST_FREEZE: assert property (!i_ce |=> $stable(o_state))
    else $error("state moved with clock enable low");
  AST_RST_OFF: assert property (!live |-> o_pad_oe == '0)
    else $error("pin driven during reset");
  AST_POR_IN: assert property (o_state == SBPSC_ST_POR |-> o_core_in == '0)
    else $error("input not low in power-on state");
  AST_FLOAT: assert property (fl0 |-> !o_pad_oe[0] && !o_core_in[0])
    else $error("floated port still active");
endmodule // sbpsc_chk
`default_nettype wire

// [test/standby_pin_state_control_bench.sv]
// testbench: state walk and pin behaviour of the pin state control block
`timescale 1ns/1ps
`default_nettype none
module standby_pin_state_control_bench;
  import sbpsc_pkg::*;
  localparam int NP = 2;
  logic clk = 0, srst = 1, pwr = 0, sreq = 0, wake = 0, ostp = 0, standby_pin_level_select = 0;
  logic rst_n = 0, ocore = 0, ce = 1, pu, rin, opo, ooe, oci, ir;
  logic [NP*SBPSC_FN_W-1:0] fn = '0;
  logic [NP-1:0] cout = '0, coe = '0, tr = '0, pin = '0, ci, po, poe;
  logic [2:0] st;
  int err_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  sbpsc_top #(.NUM_PINS(NP), .INTRST_CYC(2)) DUT (
    .i_mclk(clk), .i_srst(srst), .i_ce(ce), .i_power_stable(pwr),
    .i_stby_req(sreq), .i_wake(wake), .i_osc_stop(ostp),
    .i_standby_pin_level_select(standby_pin_level_select), .i_external_reset_low_input_n(rst_n),
    .o_rst_pullup_en(pu), .o_rst_in(rin), .i_osc_core_out(ocore),
    .o_osc_pad_out(opo), .o_osc_pad_oe(ooe), .o_osc_core_in(oci),
    .i_fn_sel(fn), .i_core_out(cout), .i_core_oe(coe), .i_trace_out(tr),
    .i_pad_in(pin), .o_core_in(ci), .o_pad_out(po), .o_pad_oe(poe),
    .o_state(st), .o_int_reset(ir));
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_b(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t pin got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_s(input logic [2:0] e);
    n_checks++;
    if (st !== e) begin
      err_count++;
      $display("MISMATCH t=%0t state got %h exp %h", $time, st, e);
    end
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 40 && st !== s; i++) step(1);
    chk_s(s);
    if (st !== s) wrap_up();
  endtask
  // one-cycle request pulse: wake when w, else standby
  task automatic pulse(input logic w);
    wake = w;
    sreq = !w;
    step(1);
    wake = 0;
    sreq = 0;
  endtask
  task automatic t_boot();
    chk_s(SBPSC_ST_POR);
    pwr = 1;
    step(1);
    chk_s(SBPSC_ST_RSTIN);
    chk_b(opo, 1);
    chk_b(rin, rst_n);
    chk_b(oci, 0);
    chk_b(ooe, 1);
    rst_n = 1;
    step(1);
    chk_s(SBPSC_ST_INTRST);
    wait_st(SBPSC_ST_RUN);
  endtask
  task automatic t_hold();
    fn = {SBPSC_FN_EXTINT, SBPSC_FN_GPIO};
    {cout, coe, standby_pin_level_select} = {4'hF, 1'h0};
    step(1);
    pulse(0);
    chk_s(SBPSC_ST_STBY);
    cout = 0;
    pin = 2'h1;
    #1;
    chk_b(po[0] & poe[0], 1);
    chk_b(ci[0], 1);
    chk_b(po[1], 0);
    fn[5:3] = SBPSC_FN_TRACE;
    #1;
    chk_b(poe[1], 1);
    fn[5:3] = SBPSC_FN_EXTINT;
    pulse(1);
    chk_s(SBPSC_ST_RUN);
  endtask
  task automatic t_float();
    {cout, standby_pin_level_select} = {2'h3, 1'h1};
    pulse(0);
    chk_b(poe[0] | ci[0], 0);
    chk_b(po[1] & poe[1], 1);
    fn[2:0] = SBPSC_FN_TRACE;
    tr = 2'h1;
    #1;
    chk_b(po[0] & poe[0], 1);
    tr = 0;
    #1;
    chk_b(po[0], 0);
    fn = {SBPSC_FN_NMI, SBPSC_FN_PERIPH};
    #1;
    chk_b(po[1] & poe[1], 1);
    chk_b(poe[0], 0);
    fn[5:3] = SBPSC_FN_JTAG;
    #1;
    chk_b(po[1] & poe[1], 1);
    fn = {SBPSC_FN_EXTINT, SBPSC_FN_TRACE};
    pulse(1);
  endtask
  task automatic t_freeze();
    ce = 0;
    pulse(0);
    chk_s(SBPSC_ST_RUN);
    ce = 1;
    step(1);
    chk_s(SBPSC_ST_RUN);
  endtask
  task automatic t_osc();
    ostp = 0;
    #1;
    chk_b(opo, 0);
    ostp = 1;
    #1;
    chk_b(opo, 1);
    ostp = 0;
  endtask
  task automatic t_pin();
    rst_n = 0;
    step(1);
    chk_s(SBPSC_ST_RSTIN);
    chk_b(pu, 1);
    rst_n = 1;
    wait_st(SBPSC_ST_RUN);
    pwr = 0;
    step(1);
    chk_s(SBPSC_ST_POR);
  endtask
  initial begin
    step(8);
    srst = 0;
    t_boot();
    t_hold();
    t_float();
    t_osc();
    t_freeze();
    t_pin();
    wrap_up();
  end
endmodule // standby_pin_state_control_bench
bind sbpsc_top sbpsc_chk #(.NUM_PINS(NUM_PINS)) u_chk (.i_mclk, .i_srst, .i_ce,
  .i_power_stable, .i_external_reset_low_input_n, .i_osc_stop,
  .i_standby_pin_level_select, .i_fn_sel, .o_rst_pullup_en, .o_rst_in,
  .o_osc_pad_out, .o_osc_core_in, .o_core_in, .o_pad_oe, .o_state,
  .o_int_reset);
`default_nettype wire
